//--- hdl/hci_pkg.sv
// shared constants and types of the host command interpreter
package hci_pkg;

	// ----------------------------------------------------------------
	// reply queue sizing
	// ----------------------------------------------------------------
	localparam int         TXQ_DEPTH  = 16;
	localparam logic [4:0] LEN_ONE    = 5'h01;
	localparam logic [4:0] LEN_DBG    = 5'h02;
	localparam logic [4:0] LEN_VALUES = 5'h06;
	localparam logic [4:0] LEN_EXTVAL = 5'h08;
	localparam logic [4:0] LEN_CALRD  = 5'h09;
	localparam logic [4:0] LEN_INFO   = 5'h10;

	// ----------------------------------------------------------------
	// host command bytes
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_HANDSHAKE = 8'h52;
	localparam logic [7:0] CMD_EXT_HS    = 8'h72;
	localparam logic [7:0] CMD_VALUES    = 8'h56;
	localparam logic [7:0] CMD_EXT_VAL   = 8'h76;
	localparam logic [7:0] CMD_CAL_READ  = 8'h4B;
	localparam logic [7:0] CMD_CAL_WRITE = 8'h6B;
	localparam logic [7:0] CMD_RNG_READ  = 8'h47;
	localparam logic [7:0] CMD_RNG_SET   = 8'h67;
	localparam logic [7:0] CMD_INFO      = 8'h49;
	localparam logic [7:0] CMD_DBG_ON    = 8'h55;
	localparam logic [7:0] CMD_DBG_OFF   = 8'h75;
	localparam logic [7:0] CMD_SELF_CAL  = 8'h51;

	// ----------------------------------------------------------------
	// reply characters
	// ----------------------------------------------------------------
	localparam logic [7:0] CH_N    = 8'h4E;
	localparam logic [7:0] CH_ID   = 8'h5A;
	localparam logic [7:0] CH_LX   = 8'h78;
	localparam logic [7:0] CH_LY   = 8'h79;
	localparam logic [7:0] CH_LZ   = 8'h7A;
	localparam logic [7:0] CH_B    = 8'h62;
	localparam logic [7:0] CH_UX   = 8'h58;
	localparam logic [7:0] CH_UY   = 8'h59;
	localparam logic [7:0] CH_UZ   = 8'h5A;
	localparam logic [7:0] CH_C    = 8'h63;
	localparam logic [7:0] CH_Q    = 8'h51;
	localparam logic [7:0] CH_K    = 8'h4B;
	localparam logic [7:0] CH_0    = 8'h30;
	localparam logic [7:0] CH_3    = 8'h33;
	localparam logic [7:0] CH_9    = 8'h39;
	localparam logic [7:0] CH_A    = 8'h41;
	localparam logic [7:0] CH_F    = 8'h46;
	localparam logic [7:0] BTN_MASK = 8'h03;

	// ----------------------------------------------------------------
	// sequence counts and default info text
	// ----------------------------------------------------------------
	localparam logic [2:0] CAL_LAST_ARG = 3'h5;
	localparam logic [1:0] QSTEP_SEND   = 2'h3;
	localparam logic [127:0] INFO_DEFAULT = "v1.0 b000 hci \r\n";

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] x;
		logic [7:0] y;
		logic [7:0] z;
		logic [7:0] btn;
		logic [1:0] rng;
	} hci_sample_s;

	typedef struct packed {
		logic [7:0] x_zero_g_value;
		logic [7:0] x_one_g_value;
		logic [7:0] y_zero_g_value;
		logic [7:0] y_one_g_value;
		logic [7:0] z_zero_g_value;
		logic [7:0] z_one_g_value;
	} hci_cal_s;

	typedef enum logic [2:0] {
		HCI_ST_CMD     = 3'b001,
		HCI_ST_CAL_ARG = 3'b010,
		HCI_ST_RNG_ARG = 3'b100
	} hci_st_e;

endpackage

//--- hdl/hci_txq.sv
// reply byte queue: loads a whole reply, sends it byte by byte
`timescale 1ns/100ps
module hci_txq import hci_pkg::*; #(
	parameter int DEPTH = TXQ_DEPTH
) (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               rst,
	// load side
	input  wire logic               load,
	input  wire logic [4:0]         load_len,
	input  wire logic [DEPTH*8-1:0] load_bytes,
	// host side
	input  wire logic               tx_ready,
	output logic                    tx_valid,
	output logic [7:0]              tx_data,
	output logic                    busy
);

	typedef struct packed {
		logic [DEPTH*8-1:0] shreg;
		logic [4:0]         cnt;
		logic               vld;
	} hci_txq_s;

	hci_txq_s s_ff;
	hci_txq_s nxt_s;

	// ----------------------------------------------------------------
	// shift out, first byte in the top lane
	// ----------------------------------------------------------------
	always_comb begin
		nxt_s = s_ff;
		if (s_ff.vld && tx_ready) begin
			nxt_s.shreg = {s_ff.shreg[DEPTH*8-9:0], 8'h00};
			nxt_s.cnt   = s_ff.cnt - 5'h01;
		end
		// a load while busy is dropped; the caller never does that
		if (load && !s_ff.vld) begin
			nxt_s.shreg = load_bytes;
			nxt_s.cnt   = load_len;
		end
		nxt_s.vld = (nxt_s.cnt != 5'h00);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign tx_valid = s_ff.vld;
	assign tx_data  = s_ff.shreg[DEPTH*8-1 -: 8];
	assign busy     = s_ff.vld;

endmodule

//--- hdl/hci_main.sv
// host command interpreter of the receiver dongle
`timescale 1ns/100ps
module hci_main import hci_pkg::*; #(
	parameter logic [TXQ_DEPTH*8-1:0] INFO_TEXT = INFO_DEFAULT
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// host byte stream in
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_data,
	output logic             rx_ready,
	// host byte stream out
	input  wire logic        tx_ready,
	output logic             tx_valid,
	output logic [7:0]       tx_data,
	// radio receive side
	input  wire logic        link_up,
	input  wire logic        samp_valid,
	input  wire hci_sample_s samp_in,
	input  wire logic        conn_valid,
	input  wire hci_cal_s    conn_cal,
	input  wire logic [3:0]  conn_ch,
	// radio transmit side
	output logic             oa_cal_pend,
	output hci_cal_s         oa_cal,
	output logic             oa_rng_pend,
	output logic [1:0]       oa_rng,
	// channel and debug control
	output logic             forced_ch_en,
	output logic [3:0]       forced_ch,
	output logic             debug_en
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic is_hex(input logic [7:0] c);
		return ((c >= CH_0) && (c <= CH_9)) || ((c >= CH_A) && (c <= CH_F));
	endfunction

	function automatic logic [3:0] hex_val(input logic [7:0] c);
		return (c <= CH_9) ? c[3:0] : 4'(c[3:0] + 4'h9);
	endfunction

	function automatic logic [7:0] hex_char(input logic [3:0] v);
		return (v < 4'hA) ? {4'h3, v} : 8'(CH_A + {4'h0, v} - 8'h0A);
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		hci_st_e     st;
		logic [2:0]  argn;
		hci_cal_s    cal_wr;
		hci_cal_s    cal_rd;
		hci_sample_s samp;
		logic        dbg;
		logic        dbg_pend;
		logic [3:0]  dbg_ch;
		logic        fch_en;
		logic [3:0]  fch;
		logic        pend_cal;
		hci_cal_s    oa_cal;
		logic        pend_rng;
		logic [1:0]  oa_rng;
		logic [1:0]  qstep;
		hci_cal_s    qcal;
		logic        rdy;
	} hci_main_s;

	hci_main_s s_ff;
	hci_main_s nxt_s;

	logic                   take;
	logic                   tx_busy;
	logic                   load;
	logic [4:0]             load_len;
	logic [TXQ_DEPTH*8-1:0] load_bytes;

	assign take = rx_valid && s_ff.rdy;

	// ----------------------------------------------------------------
	// interpreter
	// ----------------------------------------------------------------
	always_comb begin
		nxt_s      = s_ff;
		load       = 1'b0;
		load_len   = 5'h00;
		load_bytes = '0;

		if (samp_valid) begin
			nxt_s.samp = samp_in;
		end
		// connect reply confirms any pending update; a new set below wins
		if (conn_valid) begin
			nxt_s.cal_rd   = conn_cal;
			nxt_s.pend_cal = 1'b0;
			nxt_s.pend_rng = 1'b0;
		end

		if (take) begin
			case (s_ff.st)
			HCI_ST_CAL_ARG: begin
				nxt_s.cal_wr = hci_cal_s'({s_ff.cal_wr[39:0], rx_data});
				nxt_s.argn   = 3'(s_ff.argn + 3'h1);
				if (s_ff.argn == CAL_LAST_ARG) begin
					nxt_s.st       = HCI_ST_CMD;
					nxt_s.argn     = 3'h0;
					nxt_s.oa_cal   = hci_cal_s'({s_ff.cal_wr[39:0], rx_data});
					nxt_s.pend_cal = 1'b1;
				end
			end
			HCI_ST_RNG_ARG: begin
				nxt_s.st = HCI_ST_CMD;
				// out-of-range argument is dropped
				if ((rx_data >= CH_0) && (rx_data <= CH_3)) begin
					nxt_s.oa_rng   = rx_data[1:0];
					nxt_s.pend_rng = 1'b1;
				end
			end
			default: begin
				case (rx_data)
				CMD_HANDSHAKE: begin
					load       = 1'b1;
					load_len   = LEN_ONE;
					load_bytes = {CH_N, {(TXQ_DEPTH-1)*8{1'b0}}};
					nxt_s.dbg      = 1'b0;
					nxt_s.dbg_pend = 1'b0;
					nxt_s.qstep    = 2'h0;
				end
				CMD_EXT_HS: begin
					load       = 1'b1;
					load_len   = LEN_ONE;
					load_bytes = {CH_ID, {(TXQ_DEPTH-1)*8{1'b0}}};
				end
				CMD_VALUES: begin
					load       = 1'b1;
					load_len   = LEN_VALUES;
					load_bytes = {CH_LX, s_ff.samp.x, CH_LY, s_ff.samp.y,
						CH_LZ, s_ff.samp.z, {(TXQ_DEPTH-6)*8{1'b0}}};
				end
				CMD_EXT_VAL: begin
					load       = 1'b1;
					load_len   = LEN_EXTVAL;
					// reserved button bits are sent as zero
					load_bytes = {CH_LX, s_ff.samp.x, CH_LY, s_ff.samp.y,
						CH_LZ, s_ff.samp.z, CH_B,
						s_ff.samp.btn & BTN_MASK,
						{(TXQ_DEPTH-8)*8{1'b0}}};
				end
				CMD_CAL_READ: begin
					load       = 1'b1;
					load_len   = LEN_CALRD;
					load_bytes = {CH_UX, s_ff.cal_rd.x_zero_g_value,
						s_ff.cal_rd.x_one_g_value,
						CH_UY, s_ff.cal_rd.y_zero_g_value,
						s_ff.cal_rd.y_one_g_value,
						CH_UZ, s_ff.cal_rd.z_zero_g_value,
						s_ff.cal_rd.z_one_g_value,
						{(TXQ_DEPTH-9)*8{1'b0}}};
				end
				CMD_CAL_WRITE: begin
					nxt_s.st   = HCI_ST_CAL_ARG;
					nxt_s.argn = 3'h0;
				end
				CMD_RNG_READ: begin
					// same code for either sensor; host maps it
					load       = 1'b1;
					load_len   = LEN_ONE;
					load_bytes = {CH_0 | {6'h00, s_ff.samp.rng},
						{(TXQ_DEPTH-1)*8{1'b0}}};
				end
				CMD_RNG_SET: begin
					nxt_s.st = HCI_ST_RNG_ARG;
				end
				CMD_INFO: begin
					load       = 1'b1;
					load_len   = LEN_INFO;
					load_bytes = INFO_TEXT;
				end
				CMD_DBG_ON: begin
					nxt_s.dbg = 1'b1;
				end
				CMD_DBG_OFF: begin
					nxt_s.dbg      = 1'b0;
					nxt_s.dbg_pend = 1'b0;
				end
				CMD_SELF_CAL: begin
					load       = 1'b1;
					load_len   = LEN_ONE;
					nxt_s.qstep = 2'(s_ff.qstep + 2'h1);
					case (s_ff.qstep)
					2'h0: begin
						nxt_s.qcal.z_one_g_value  = s_ff.samp.z;
						nxt_s.qcal.x_zero_g_value = s_ff.samp.x;
						nxt_s.qcal.y_zero_g_value = s_ff.samp.y;
						load_bytes = {CH_UX, {(TXQ_DEPTH-1)*8{1'b0}}};
					end
					2'h1: begin
						nxt_s.qcal.x_one_g_value = s_ff.samp.x;
						load_bytes = {CH_UY, {(TXQ_DEPTH-1)*8{1'b0}}};
					end
					2'h2: begin
						nxt_s.qcal.y_one_g_value = s_ff.samp.y;
						load_bytes = {CH_Q, {(TXQ_DEPTH-1)*8{1'b0}}};
					end
					default: begin
						nxt_s.oa_cal   = s_ff.qcal;
						nxt_s.pend_cal = 1'b1;
						load_bytes = {CH_K, {(TXQ_DEPTH-1)*8{1'b0}}};
					end
					endcase
				end
				default: begin
					// only before a link; radio reads it at next connect
					if (is_hex(rx_data) && !link_up) begin
						nxt_s.fch_en = 1'b1;
						nxt_s.fch    = hex_val(rx_data);
					end
				end
				endcase
			end
			endcase
		end

		// debug report of the newest connection, waits for a free queue
		if (!load && !tx_busy && s_ff.dbg_pend) begin
			load           = 1'b1;
			load_len       = LEN_DBG;
			load_bytes     = {CH_C, hex_char(s_ff.dbg_ch),
				{(TXQ_DEPTH-2)*8{1'b0}}};
			nxt_s.dbg_pend = 1'b0;
		end
		if (conn_valid && nxt_s.dbg) begin
			nxt_s.dbg_pend = 1'b1;
			nxt_s.dbg_ch   = conn_ch;
		end

		// no new byte while a reply is queued or going out
		nxt_s.rdy = !(load || tx_busy);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_ff    <= '0;
			s_ff.st <= HCI_ST_CMD;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// ----------------------------------------------------------------
	// reply queue
	// ----------------------------------------------------------------
	hci_txq #(
		.DEPTH      (TXQ_DEPTH)
	) u_txq (
		.clk        (clk),
		.rst        (rst),
		.load       (load),
		.load_len   (load_len),
		.load_bytes (load_bytes),
		.tx_ready   (tx_ready),
		.tx_valid   (tx_valid),
		.tx_data    (tx_data),
		.busy       (tx_busy)
	);

	assign rx_ready     = s_ff.rdy;
	assign oa_cal_pend  = s_ff.pend_cal;
	assign oa_cal       = s_ff.oa_cal;
	assign oa_rng_pend  = s_ff.pend_rng;
	assign oa_rng       = s_ff.oa_rng;
	assign forced_ch_en = s_ff.fch_en;
	assign forced_ch    = s_ff.fch;
	assign debug_en     = s_ff.dbg;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	logic cmd_take;
	assign cmd_take = take && (s_ff.st == HCI_ST_CMD);

	property p_handshake;
		cmd_take && rx_data == CMD_HANDSHAKE
			|=> tx_valid && tx_data == CH_N && !debug_en;
	endproperty
	a_handshake: assert property (p_handshake) else $error("no N");
	property p_ext_hs;
		cmd_take && rx_data == CMD_EXT_HS |=> tx_valid && tx_data == CH_ID;
	endproperty
	a_ext_hs: assert property (p_ext_hs) else $error("no id char");
	property p_values;
		cmd_take && rx_data == CMD_VALUES
			|=> tx_valid && tx_data == CH_LX && !rx_ready;
	endproperty
	a_values: assert property (p_values) else $error("bad values");
	property p_rng_read;
		cmd_take && rx_data == CMD_RNG_READ
			|=> tx_data == (CH_0 | {6'h00, $past(s_ff.samp.rng)});
	endproperty
	a_rng_read: assert property (p_rng_read) else $error("bad rng");
	// a pending debug report may go out right after; not an argument reply
	property p_rng_set;
		take && s_ff.st == HCI_ST_RNG_ARG && !s_ff.dbg_pend
			&& rx_data >= CH_0 && rx_data <= CH_3
			|=> oa_rng_pend && oa_rng == $past(rx_data[1:0]) && !tx_valid;
	endproperty
	a_rng_set: assert property (p_rng_set) else $error("no relay");
	property p_dbg_off;
		cmd_take && (rx_data == CMD_DBG_OFF || rx_data == CMD_HANDSHAKE)
			|=> !debug_en;
	endproperty
	a_dbg_off: assert property (p_dbg_off) else $error("debug on");
	property p_forced;
		cmd_take && is_hex(rx_data) && !link_up
			|=> forced_ch_en && forced_ch == hex_val($past(rx_data));
	endproperty
	a_forced: assert property (p_forced) else $error("not forced");
	property p_forced_sticky;
		forced_ch_en |=> forced_ch_en;
	endproperty
	a_forced_sticky:
		assert property (p_forced_sticky) else $error("forced lost");
	property p_arg_data;
		take && s_ff.st != HCI_ST_CMD && !s_ff.dbg_pend
			|=> $stable(forced_ch) && !tx_valid;
	endproperty
	a_arg_data: assert property (p_arg_data) else $error("as cmd");
	property p_confirm;
		conn_valid && !take |=> !oa_cal_pend && !oa_rng_pend;
	endproperty
	a_confirm: assert property (p_confirm) else $error("pend kept");

	c_ext_values: cover property (cmd_take && rx_data == CMD_EXT_VAL);
	c_cal_write:  cover property (take && s_ff.st == HCI_ST_CAL_ARG
		&& s_ff.argn == CAL_LAST_ARG);
	c_self_cal:   cover property (cmd_take && rx_data == CMD_SELF_CAL
		&& s_ff.qstep == QSTEP_SEND);

endmodule

//--- sim/hci_host_model.sv
// host side model: takes reply bytes, stalls when asked to
`timescale 1ns/100ps
module hci_host_model (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// stall control
	input  wire logic slow,
	// reply stream handshake
	output logic      tx_ready
);
	int          seed;
	logic [31:0] rv;

	// ready and rv have one driver each: the clocked block below
	initial seed = 95;

	// ------------------------------------------------------------
	// ready pattern
	// ------------------------------------------------------------
	// slow mode holds ready low three cycles in four on average
	always @(negedge clk) begin
		rv = $random(seed);
		tx_ready <= !rst && (!slow || rv[1:0] == 2'h0);
	end
endmodule

//--- sim/hci_main_test.sv
// self-checking bench for the host command interpreter
`timescale 1ns/100ps
module hci_main_test import hci_pkg::*;;
	logic        clk, rst, rx_valid, rx_ready, tx_ready, tx_valid;
	logic        link_up, samp_valid, conn_valid, slow;
	logic [7:0]  rx_data, tx_data;
	logic [3:0]  conn_ch, forced_ch;
	logic        oa_cal_pend, oa_rng_pend, forced_ch_en, debug_en;
	logic [1:0]  oa_rng;
	hci_sample_s samp_in, s;
	hci_sample_s sq [3];
	hci_cal_s    conn_cal, oa_cal, cal;
	logic [63:0] rv;
	logic [7:0]  pr [4];
	logic [7:0]  expq [$];
	int          n_mismatch, n_checks, cycles, seed;

	hci_main hci_main_inst (
		.clk(clk), .rst(rst), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_ready(rx_ready), .tx_ready(tx_ready), .tx_valid(tx_valid),
		.tx_data(tx_data), .link_up(link_up), .samp_valid(samp_valid),
		.samp_in(samp_in), .conn_valid(conn_valid), .conn_cal(conn_cal),
		.conn_ch(conn_ch), .oa_cal_pend(oa_cal_pend), .oa_cal(oa_cal),
		.oa_rng_pend(oa_rng_pend), .oa_rng(oa_rng),
		.forced_ch_en(forced_ch_en), .forced_ch(forced_ch),
		.debug_en(debug_en)
	);

	hci_host_model hci_host_model_inst (
		.clk(clk), .rst(rst), .slow(slow), .tx_ready(tx_ready)
	);

	initial clk = 1'b0;
	always #2.5 clk = ~clk;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic finish_test;
		$display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// byte held until rx_ready seen, released after the taking edge
	task automatic xfer(input logic [7:0] b);
		@(negedge clk);
		rx_valid = 1'b1;
		rx_data  = b;
		while (rx_ready !== 1'b1)
			@(negedge clk);
		@(negedge clk);
		rx_valid = 1'b0;
		rx_data  = ~b;
	endtask

	task automatic drain;
		repeat (3) @(negedge clk);
		while (expq.size() != 0)
			@(negedge clk);
	endtask

	// expected reply bytes sit left aligned in rep
	task automatic cmd(input logic [7:0] b, input logic [127:0] rep,
			input int n);
		for (int i = 0; i < n; i++)
			expq.push_back(rep[127-8*i -: 8]);
		xfer(b);
		drain();
	endtask

	task automatic sample(input hci_sample_s v);
		@(negedge clk);
		samp_in    = v;
		samp_valid = 1'b1;
		@(negedge clk);
		samp_valid = 1'b0;
	endtask

	task automatic connect(input hci_cal_s c, input logic [3:0] ch);
		@(negedge clk);
		conn_cal   = c;
		conn_ch    = ch;
		conn_valid = 1'b1;
		@(negedge clk);
		conn_valid = 1'b0;
		repeat (2) @(negedge clk);
	endtask

	// ------------------------------------------------------------
	// reply watcher and timeout
	// ------------------------------------------------------------
	// any byte with no note waiting is a stray reply
	always @(posedge clk) begin
		if (rst === 1'b0 && tx_valid === 1'b1 && tx_ready === 1'b1) begin
			if (expq.size() == 0)
				check({56'h0, tx_data}, 64'hFFFF);
			else
				check({56'h0, tx_data}, {56'h0, expq.pop_front()});
		end
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			finish_test();
		end
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		{rx_valid, link_up, samp_valid, conn_valid, slow} = 5'h00;
		{rx_data, conn_ch, samp_in, conn_cal} = '0;
		n_mismatch = 0;
		n_checks   = 0;
		cycles     = 0;
		seed       = 95;
		pr         = '{CH_UX, CH_UY, CH_Q, CH_K};
		rst        = 1'b1;
		repeat (6) @(negedge clk);
		rst = 1'b0;
		cmd(CMD_HANDSHAKE, {CH_N, 120'h0}, 1);
		cmd(CMD_EXT_HS, {CH_ID, 120'h0}, 1);
		cmd(8'h00, '0, 0);
		cmd(8'h7E, '0, 0);
		for (int r = 0; r < 4; r++) begin
			rv     = {$random(seed), $random(seed)};
			s      = hci_sample_s'(rv[33:0]);
			s.rng  = r[1:0];
			slow   = rv[40];
			sample(s);
			cmd(CMD_VALUES, {CH_LX, s.x, CH_LY, s.y, CH_LZ, s.z, 80'h0}, 6);
			cmd(CMD_EXT_VAL, {CH_LX, s.x, CH_LY, s.y, CH_LZ, s.z, CH_B,
				s.btn & BTN_MASK, 64'h0}, 8);
			cmd(CMD_RNG_READ, {CH_0 + {6'h0, s.rng}, 120'h0}, 1);
		end
		slow = 1'b1;
		rv   = {$random(seed), $random(seed)};
		cal  = hci_cal_s'(rv[47:0]);
		connect(cal, 4'h2);
		cmd(CMD_CAL_READ, {CH_UX, cal.x_zero_g_value, cal.x_one_g_value,
			CH_UY, cal.y_zero_g_value, cal.y_one_g_value, CH_UZ,
			cal.z_zero_g_value, cal.z_one_g_value, 56'h0}, 9);
		// argument bytes that look like commands must stay data
		rv  = {$random(seed), $random(seed)};
		cal = hci_cal_s'(rv[47:0]);
		cal.y_zero_g_value = CMD_HANDSHAKE;
		cal.z_one_g_value  = 8'h37;
		xfer(CMD_CAL_WRITE);
		for (int i = 0; i < 6; i++)
			xfer(cal[47-8*i -: 8]);
		drain();
		check({63'h0, oa_cal_pend}, 64'h1);
		check({16'h0, oa_cal}, {16'h0, cal});
		xfer(CMD_RNG_SET);
		xfer(CH_0 + 8'h02);
		drain();
		check({61'h0, oa_rng_pend, oa_rng}, 64'h6);
		check({63'h0, forced_ch_en}, 64'h0);
		repeat (20) @(negedge clk);
		check({62'h0, oa_cal_pend, oa_rng_pend}, 64'h3);
		connect(cal, 4'h2);
		check({62'h0, oa_cal_pend, oa_rng_pend}, 64'h0);
		xfer(CMD_RNG_SET);
		xfer(8'h34);
		drain();
		check({63'h0, oa_rng_pend}, 64'h0);
		cmd(CMD_INFO, INFO_DEFAULT, 16);
		cmd(CMD_DBG_ON, '0, 0);
		check({63'h0, debug_en}, 64'h1);
		expq.push_back(CH_C);
		expq.push_back(CH_0 + 8'h05);
		connect(cal, 4'h5);
		drain();
		cmd(CMD_DBG_OFF, '0, 0);
		check({63'h0, debug_en}, 64'h0);
		connect(cal, 4'h5);
		cmd(CMD_DBG_ON, '0, 0);
		cmd(CMD_HANDSHAKE, {CH_N, 120'h0}, 1);
		check({63'h0, debug_en}, 64'h0);
		cmd(8'h37, '0, 0);
		check({59'h0, forced_ch_en, forced_ch}, 64'h17);
		cmd(8'h43, '0, 0);
		check({59'h0, forced_ch_en, forced_ch}, 64'h1C);
		link_up = 1'b1;
		cmd(8'h33, '0, 0);
		check({59'h0, forced_ch_en, forced_ch}, 64'h1C);
		cmd(CMD_HANDSHAKE, {CH_N, 120'h0}, 1);
		check({63'h0, forced_ch_en}, 64'h1);
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst     = 1'b0;
		link_up = 1'b0;
		check({63'h0, forced_ch_en}, 64'h0);
		for (int i = 0; i < 4; i++) begin
			if (i < 3) begin
				rv    = {$random(seed), $random(seed)};
				sq[i] = hci_sample_s'(rv[33:0]);
				sample(sq[i]);
			end
			cmd(CMD_SELF_CAL, {pr[i], 120'h0}, 1);
		end
		check({63'h0, oa_cal_pend}, 64'h1);
		check({24'h0, oa_cal.x_zero_g_value, oa_cal.x_one_g_value,
			oa_cal.y_zero_g_value, oa_cal.y_one_g_value,
			oa_cal.z_one_g_value}, {24'h0, sq[0].x, sq[1].x, sq[0].y,
			sq[2].y, sq[0].z});
		finish_test();
	end
endmodule
